// *** amr_pkg.sv ***
// Constants, field layouts and carrier types of the measurement monitor.
// Assumes a single 40 MHz clock and an APB register master.
package amr_pkg;

  localparam int NUM_CH = 5;
  localparam int CODE_W = 10;
  localparam int PERIOD_W = 16;
  localparam int TICK_W = 16;

  // Channel numbers as seen by software
  localparam logic [2:0] CH_SUPPLY = 3'h5;
  localparam logic [2:0] CH_TEMP = 3'h4;
  localparam logic [2:0] CH_GP_LAST = 3'h3;
  localparam logic [2:0] CH_FIRST = 3'h1;

  // Register byte offsets
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_SLEEP = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_MASK = 8'h0c;
  localparam logic [7:0] REG_RESULT = 8'h10;
  localparam logic [7:0] REG_POWER = 8'h14;
  // Per-channel page: paddr[7:4] = page, channel = page - 1
  localparam logic [3:0] CH_FIRST_PAGE = 4'h2;
  localparam logic [3:0] CH_LAST_PAGE = 4'h6;
  localparam logic [1:0] CH_MODE = 2'h0;
  localparam logic [1:0] CH_PERIOD = 2'h1;
  localparam logic [1:0] CH_LIMITS = 2'h2;
  localparam logic [1:0] CH_LAST = 2'h3;

  // Field positions
  localparam int CMD_START_BIT = 8;
  localparam int MODE_UPEN_BIT = 2;
  localparam int MODE_LOEN_BIT = 3;
  localparam int LIM_LO_LSB = 0;
  localparam int LIM_UP_LSB = 16;
  localparam int RES_CH_LSB = 12;
  localparam int RES_BUSY_BIT = 16;

  // Status bits
  localparam int ST_W = 4;
  localparam int ST_SINGLE = 0;
  localparam int ST_PERIODIC = 1;
  localparam int ST_LIMIT = 2;
  localparam int ST_BADCMD = 3;

  // Channel modes
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_PERIODIC = 2'h1;
  localparam logic [1:0] MODE_LIMITS = 2'h2;

  // Conversion sources and report kinds
  localparam logic [1:0] SRC_BG = 2'h0;
  localparam logic [1:0] SRC_SINGLE = 2'h1;
  localparam logic [1:0] SRC_PERIOD = 2'h2;
  localparam logic [1:0] REP_SINGLE = 2'h0;
  localparam logic [1:0] REP_PERIODIC = 2'h1;
  localparam logic [1:0] REP_LIMIT = 2'h2;

  // Scaling to host units
  localparam logic [9:0] SUPPLY_BASE = 10'h12c;
  localparam logic [9:0] SUPPLY_SPAN = 10'h096;
  localparam logic [9:0] GP_SPAN = 10'h0e6;
  localparam logic [9:0] TEMP_COLD_CODE = 10'h0e5;
  localparam logic [9:0] TEMP_HOT_CODE = 10'h011;

  // Reset values
  localparam logic [PERIOD_W-1:0] PERIOD_RST = 16'h0001;
  localparam logic [PERIOD_W-1:0] SLEEP_RST = 16'h0000;
  localparam logic [ST_W-1:0] MASK_RST = 4'h0;

  // Timing: period and sleep delay count in ticks of this length
  localparam int CLK_PERIOD_NS = 25;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;

  typedef struct packed {
    logic [1:0] kind;
    logic [2:0] chan;
    logic [CODE_W-1:0] value;
  } amr_report_t;

  typedef struct packed {
    logic [1:0] mode;
    logic up_en;
    logic lo_en;
    logic [PERIOD_W-1:0] period;
    logic [CODE_W-1:0] lower;
    logic [CODE_W-1:0] upper;
  } amr_chcfg_t;

endpackage

// *** amr_monitor.sv ***
// Five-channel measurement scheduler, scaler and reporter with APB regs.
// Assumes a converter on the same clock: start pulse, later done + code.
`timescale 1ns/1ps

// What this block does
// - Five measurement channels, each yielding a ten-bit code.
// - Channel 5 supply, 4 temperature, 3 to 1 external inputs.
// - External inputs span 0 to 2.3 V, reported as volts times 100.
// - Single command makes exactly one conversion and returns its result.
// - Periodic mode converts at host rate, one report per conversion.
// - Limit mode reports a periodic conversion only when a limit is crossed.
// - Period not above sleep delay keeps the device out of low power.
// - Supply is measured continuously on an internal channel.
// - Supply reported as volts times 100 over 3.0 to 4.5 V.
// - Temperature is measured continuously on an internal channel.
// - Temperature reported as raw code, 229 cold down to 17 hot.
module amr_monitor
  import amr_pkg::*;
#(
  parameter int unsigned TICK_CYCLES_P = TICK_CYCLES
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic conv_start,
  output logic [2:0] conv_sel,
  input wire logic conv_done,
  input wire logic [CODE_W-1:0] conv_code,
  output amr_report_t report,
  output logic report_valid,
  output logic sleep_inhibit,
  output logic irq
);

  typedef enum logic {S_IDLE, S_CONV} amr_state_t;

  amr_state_t state_q;
  amr_chcfg_t cfg_q [NUM_CH];
  logic [CODE_W-1:0] last_q [NUM_CH];
  logic [PERIOD_W-1:0] cnt_q [NUM_CH];
  logic [NUM_CH-1:0] due_q, due_set, inh;
  logic [TICK_W-1:0] tick_cnt_q;
  logic tick_q;
  logic [31:0] prdata_q, rdata_d;
  logic pready_q, pslverr_q, rd_err_d;
  logic conv_start_q, report_valid_q, sleep_inhibit_q, irq_q;
  logic [2:0] conv_sel_q, single_ch_q, bg_ch_q;
  logic [1:0] cur_src_q;
  logic single_pend_q, bg_pend_q;
  logic [PERIOD_W-1:0] sleep_q;
  logic [ST_W-1:0] status_q, status_set, mask_q;
  logic [CODE_W-1:0] result_q;
  logic [2:0] result_ch_q;
  amr_report_t report_q;
  logic acc, wr_acc, ch_region, pick_valid, start, done_acc, busy;
  logic [2:0] ch_idx, pick_ch, cur_idx, cmd_ch;
  logic [1:0] pick_src;
  logic [CODE_W-1:0] scaled;
  amr_chcfg_t cur_cfg, rd_cfg;
  logic limit_hit, rep_single, rep_per, rep_lim, cmd_ok;

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign conv_start = conv_start_q;
  assign conv_sel = conv_sel_q;
  assign report = report_q;
  assign report_valid = report_valid_q;
  assign sleep_inhibit = sleep_inhibit_q;
  assign irq = irq_q;

  // Maps a converter code onto host units per channel
  function automatic logic [CODE_W-1:0] scale_code(input logic [2:0] ch,
                                                   input logic [9:0] code);
    logic [19:0] prod;
    prod = 20'h00000;
    scale_code = code;
    case (ch)
      CH_SUPPLY: begin
        prod = {10'h000, code} * {10'h000, SUPPLY_SPAN};
        scale_code = SUPPLY_BASE + prod[19:10];
      end
      CH_TEMP: begin
        // Raw code kept; out-of-range codes pinned to the band ends
        if (code > TEMP_COLD_CODE) begin
          scale_code = TEMP_COLD_CODE;
        end else if (code < TEMP_HOT_CODE) begin
          scale_code = TEMP_HOT_CODE;
        end
      end
      default: begin
        prod = {10'h000, code} * {10'h000, GP_SPAN};
        scale_code = prod[19:10];
      end
    endcase
  endfunction

  // APB decode; one wait state so read data comes from a flop
  assign acc = psel && penable && pready_q;
  assign wr_acc = acc && pwrite;
  assign ch_region = (paddr[11:8] == 4'h0) && (paddr[7:4] >= CH_FIRST_PAGE)
                     && (paddr[7:4] <= CH_LAST_PAGE);
  assign ch_idx = 3'(paddr[7:4] - CH_FIRST_PAGE);
  assign rd_cfg = cfg_q[ch_idx];
  assign cmd_ch = pwdata[2:0];
  assign cmd_ok = (cmd_ch >= CH_FIRST) && (cmd_ch <= CH_SUPPLY)
                  && !single_pend_q;
  assign busy = single_pend_q || (state_q == S_CONV && cur_src_q == SRC_SINGLE);

  always_comb begin
    rdata_d = 32'h00000000;
    rd_err_d = 1'b0;
    if (ch_region) begin
      case (paddr[3:2])
        CH_MODE: rdata_d[3:0] = {rd_cfg.lo_en, rd_cfg.up_en, rd_cfg.mode};
        CH_PERIOD: rdata_d[PERIOD_W-1:0] = rd_cfg.period;
        CH_LIMITS: begin
          rdata_d[LIM_LO_LSB +: CODE_W] = rd_cfg.lower;
          rdata_d[LIM_UP_LSB +: CODE_W] = rd_cfg.upper;
        end
        default: rdata_d[CODE_W-1:0] = last_q[ch_idx];
      endcase
    end else if (paddr[11:8] != 4'h0) begin
      rd_err_d = 1'b1;
    end else begin
      case (paddr[7:0])
        REG_CMD: begin
          rdata_d[2:0] = single_ch_q;
          rdata_d[CMD_START_BIT] = single_pend_q;
        end
        REG_SLEEP: rdata_d[PERIOD_W-1:0] = sleep_q;
        REG_STATUS: rdata_d[ST_W-1:0] = status_q;
        REG_MASK: rdata_d[ST_W-1:0] = mask_q;
        REG_RESULT: begin
          rdata_d[CODE_W-1:0] = result_q;
          rdata_d[RES_CH_LSB +: 3] = result_ch_q;
          rdata_d[RES_BUSY_BIT] = busy;
        end
        REG_POWER: rdata_d[0] = sleep_inhibit_q;
        default: rd_err_d = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pready_q <= 1'b0;
      prdata_q <= 32'h00000000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= psel && penable && !pready_q;
      if (psel && penable && !pready_q) begin
        prdata_q <= pwrite ? 32'h00000000 : rdata_d;
        pslverr_q <= rd_err_d;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sleep_q <= SLEEP_RST;
      mask_q <= MASK_RST;
    end else if (wr_acc && paddr[11:8] == 4'h0) begin
      if (paddr[7:0] == REG_SLEEP) begin
        sleep_q <= pwdata[PERIOD_W-1:0];
      end
      if (paddr[7:0] == REG_MASK) begin
        mask_q <= pwdata[ST_W-1:0];
      end
    end
  end

  // Tick base for periods and the background supply/temperature scan
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b0;
    end else if (tick_cnt_q == TICK_W'(TICK_CYCLES_P - 1)) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 1'b1;
      tick_q <= 1'b0;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
      localparam logic [2:0] CH_NUM = 3'(gi + 1);
      logic sel_w;
      assign sel_w = wr_acc && ch_region && ch_idx == 3'(gi);
      assign due_set[gi] = cfg_q[gi].mode != MODE_OFF && tick_q
                           && cnt_q[gi] <= 16'h0001;
      assign inh[gi] = cfg_q[gi].mode != MODE_OFF
                       && cfg_q[gi].period <= sleep_q;

      always_ff @(posedge clock) begin
        if (!rst_n) begin
          cfg_q[gi] <= '{MODE_OFF, 1'b0, 1'b0, PERIOD_RST, '0, '0};
        end else if (sel_w) begin
          case (paddr[3:2])
            CH_MODE: begin
              cfg_q[gi].mode <= pwdata[1:0];
              cfg_q[gi].up_en <= pwdata[MODE_UPEN_BIT];
              cfg_q[gi].lo_en <= pwdata[MODE_LOEN_BIT];
            end
            CH_PERIOD: cfg_q[gi].period <= pwdata[PERIOD_W-1:0];
            CH_LIMITS: begin
              cfg_q[gi].lower <= pwdata[LIM_LO_LSB +: CODE_W];
              cfg_q[gi].upper <= pwdata[LIM_UP_LSB +: CODE_W];
            end
            default: ;
          endcase
        end
      end

      always_ff @(posedge clock) begin
        if (!rst_n) begin
          cnt_q[gi] <= PERIOD_RST;
          due_q[gi] <= 1'b0;
        end else if (cfg_q[gi].mode == MODE_OFF) begin
          cnt_q[gi] <= cfg_q[gi].period;
          due_q[gi] <= 1'b0;
        end else begin
          if (due_set[gi]) begin
            cnt_q[gi] <= cfg_q[gi].period;
          end else if (tick_q) begin
            cnt_q[gi] <= cnt_q[gi] - 1'b1;
          end
          // A new due wins over the grant of the previous one
          due_q[gi] <= (due_q[gi] && !(start && pick_src == SRC_PERIOD
                        && pick_ch == CH_NUM)) || due_set[gi];
        end
      end

      always_ff @(posedge clock) begin
        if (!rst_n) begin
          last_q[gi] <= '0;
        end else if (done_acc && conv_sel_q == CH_NUM) begin
          last_q[gi] <= scaled;
        end
      end
    end
  endgenerate

  // Single request first, then lowest periodic channel, then background
  always_comb begin
    pick_valid = 1'b0;
    pick_ch = CH_SUPPLY;
    pick_src = SRC_BG;
    if (single_pend_q) begin
      pick_valid = 1'b1;
      pick_ch = single_ch_q;
      pick_src = SRC_SINGLE;
    end else if (|due_q) begin
      pick_valid = 1'b1;
      pick_src = SRC_PERIOD;
      for (int i = NUM_CH - 1; i >= 0; i--) begin
        if (due_q[i]) begin
          pick_ch = 3'(i + 1);
        end
      end
    end else if (bg_pend_q) begin
      pick_valid = 1'b1;
      pick_ch = bg_ch_q;
    end
  end

  assign start = state_q == S_IDLE && pick_valid;
  assign done_acc = state_q == S_CONV && conv_done;
  assign cur_idx = 3'(conv_sel_q - 3'h1);
  assign cur_cfg = cfg_q[cur_idx];
  assign scaled = scale_code(conv_sel_q, conv_code);
  assign limit_hit = (cur_cfg.up_en && scaled > cur_cfg.upper)
                     || (cur_cfg.lo_en && scaled < cur_cfg.lower);
  assign rep_single = cur_src_q == SRC_SINGLE;
  assign rep_per = cur_src_q == SRC_PERIOD && cur_cfg.mode == MODE_PERIODIC;
  assign rep_lim = cur_src_q == SRC_PERIOD && cur_cfg.mode == MODE_LIMITS
                   && limit_hit;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_q <= S_IDLE;
      conv_start_q <= 1'b0;
      conv_sel_q <= CH_SUPPLY;
      cur_src_q <= SRC_BG;
    end else begin
      conv_start_q <= start;
      case (state_q)
        S_IDLE: begin
          if (pick_valid) begin
            state_q <= S_CONV;
            conv_sel_q <= pick_ch;
            cur_src_q <= pick_src;
          end
        end
        S_CONV: begin
          if (conv_done) begin
            state_q <= S_IDLE;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // Command intake; one outstanding single request at a time
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      single_pend_q <= 1'b0;
      single_ch_q <= CH_FIRST;
    end else if (wr_acc && paddr == {4'h0, REG_CMD} && pwdata[CMD_START_BIT]
                 && cmd_ok) begin
      single_pend_q <= 1'b1;
      single_ch_q <= cmd_ch;
    end else if (start && pick_src == SRC_SINGLE) begin
      single_pend_q <= 1'b0;
    end
  end

  // Background scan alternates supply and temperature once per tick
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      bg_pend_q <= 1'b0;
      bg_ch_q <= CH_SUPPLY;
    end else begin
      bg_pend_q <= (bg_pend_q && !(start && pick_src == SRC_BG)) || tick_q;
      if (start && pick_src == SRC_BG) begin
        bg_ch_q <= (bg_ch_q == CH_SUPPLY) ? CH_TEMP : CH_SUPPLY;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      report_valid_q <= 1'b0;
      report_q <= '0;
      result_q <= '0;
      result_ch_q <= CH_FIRST;
    end else begin
      report_valid_q <= done_acc && (rep_single || rep_per || rep_lim);
      if (done_acc) begin
        report_q.chan <= conv_sel_q;
        report_q.value <= scaled;
        report_q.kind <= rep_single ? REP_SINGLE
                         : (rep_lim ? REP_LIMIT : REP_PERIODIC);
      end
      if (done_acc && rep_single) begin
        result_q <= scaled;
        result_ch_q <= conv_sel_q;
      end
    end
  end

  always_comb begin
    status_set = '0;
    status_set[ST_SINGLE] = done_acc && rep_single;
    status_set[ST_PERIODIC] = done_acc && rep_per;
    status_set[ST_LIMIT] = done_acc && rep_lim;
    status_set[ST_BADCMD] = wr_acc && paddr == {4'h0, REG_CMD}
                            && pwdata[CMD_START_BIT] && !cmd_ok;
  end

  // Write one clears; a set in the same cycle wins
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      status_q <= '0;
    end else if (wr_acc && paddr == {4'h0, REG_STATUS}) begin
      status_q <= (status_q & ~pwdata[ST_W-1:0]) | status_set;
    end else begin
      status_q <= status_q | status_set;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
      sleep_inhibit_q <= 1'b0;
    end else begin
      irq_q <= |(status_q & mask_q);
      sleep_inhibit_q <= |inh;
    end
  end

  a_conv_pulse: assert property (
    @(posedge clock) disable iff (!rst_n)
    conv_start_q |=> !conv_start_q ##1 !conv_start_q)
    else $error("conversion start not a single pulse");

  a_chan_legal: assert property (
    @(posedge clock) disable iff (!rst_n)
    conv_start_q |-> conv_sel_q >= 3'h1 && conv_sel_q <= 3'h5)
    else $error("conversion on channel outside 1 to 5");

  a_report_cause: assert property (
    @(posedge clock) disable iff (!rst_n)
    report_valid_q |-> $past(done_acc) && report_q.chan == $past(conv_sel_q))
    else $error("report without a finished conversion");

  a_limit_only_hit: assert property (
    @(posedge clock) disable iff (!rst_n)
    report_valid_q && report_q.kind == 2'h2 |->
      (cfg_q[report_q.chan - 3'h1].up_en
       && report_q.value > cfg_q[report_q.chan - 3'h1].upper)
      || (cfg_q[report_q.chan - 3'h1].lo_en
       && report_q.value < cfg_q[report_q.chan - 3'h1].lower))
    else $error("limit report without a crossed limit");

  a_sleep_hold: assert property (
    @(posedge clock) disable iff (!rst_n)
    (cfg_q[0].mode != 2'h0 && cfg_q[0].period <= sleep_q) [*2]
      |-> sleep_inhibit_q)
    else $error("low power allowed with short period");

  a_supply_range: assert property (
    @(posedge clock) disable iff (!rst_n)
    report_valid_q && report_q.chan == 3'h5 |->
      report_q.value >= 10'h12c && report_q.value <= 10'h1c2)
    else $error("supply report outside 300 to 450");

  a_temp_range: assert property (
    @(posedge clock) disable iff (!rst_n)
    report_valid_q && report_q.chan == 3'h4 |->
      report_q.value >= 10'h011 && report_q.value <= 10'h0e5)
    else $error("temperature code outside 17 to 229");

  a_gp_range: assert property (
    @(posedge clock) disable iff (!rst_n)
    report_valid_q && report_q.chan <= 3'h3 |->
      report_q.value <= 10'h0e6)
    else $error("external input report above 230");

  // A periodic due or a command on the same tick outranks the scan
  a_bg_scan: assert property (
    @(posedge clock) disable iff (!rst_n)
    tick_q && state_q == S_IDLE && !single_pend_q && due_q == '0
      && due_set == '0 && !wr_acc
      |-> ##[1:2] conv_start_q && (conv_sel_q == 3'h5 || conv_sel_q == 3'h4))
    else $error("background scan did not start");

endmodule

// *** amr_conv_model.sv ***
// Behavioural converter standing at the far side of the monitor.
// Assumes one clock; the bench sets the code returned for each channel.
`timescale 1ns/1ps
module amr_conv_model (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic conv_start,
  input wire logic [2:0] conv_sel,
  output logic conv_done,
  output logic [9:0] conv_code
);
  logic [9:0] codes [8];
  logic [3:0] cnt_q;
  logic [2:0] ch_q;
  logic busy_q;

  // Known codes for channels the bench never sets
  initial foreach (codes[i]) codes[i] = 10'h200;

  always @(posedge clock) begin
    conv_done <= 1'b0;
    if (!rst_n) begin
      busy_q <= 1'b0;
      cnt_q <= 4'h0;
      conv_code <= 10'h155;
    end else if (conv_start) begin
      busy_q <= 1'b1;
      ch_q <= conv_sel;
      cnt_q <= slow ? 4'h9 : 4'h1;
    end else if (busy_q && cnt_q == 4'h0) begin
      busy_q <= 1'b0;
      conv_done <= 1'b1;
      conv_code <= codes[ch_q];
    end else begin
      cnt_q <= cnt_q - 4'h1;
      // Code means nothing without done, so keep it moving
      conv_code <= ~conv_code;
    end
  end
endmodule

// *** testbench.sv ***
// Self-checking bench of the measurement monitor with a converter model.
// Assumes the monitor's APB map and a short tick for quick runs.
`timescale 1ns/1ps
module testbench;
  import amr_pkg::*;
  localparam int TK = 16;
  logic clock, rst_n, psel, penable, pwrite, slow, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat, seed;
  logic pready, pslverr, conv_start, conv_done, report_valid;
  logic sleep_inhibit, irq;
  logic [2:0] conv_sel;
  logic [9:0] conv_code, c, v;
  amr_report_t report, last;
  int mismatches, n_compared, k0;
  int n_kind [4];
  int seen [8];

  amr_monitor #(.TICK_CYCLES_P(TK)) dut (.clock(clock), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .conv_start(conv_start), .conv_sel(conv_sel), .conv_done(conv_done),
    .conv_code(conv_code), .report(report), .report_valid(report_valid),
    .sleep_inhibit(sleep_inhibit), .irq(irq));
  amr_conv_model conv (.clock(clock), .rst_n(rst_n), .slow(slow),
    .conv_start(conv_start), .conv_sel(conv_sel), .conv_done(conv_done),
    .conv_code(conv_code));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  always @(posedge clock) begin
    if (report_valid === 1'b1) begin
      last <= report;
      n_kind[report.kind]++;
    end
    if (conv_start === 1'b1) seen[conv_sel]++;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Host units: supply and inputs in volts times 100, temperature raw
  function automatic logic [9:0] scale(input logic [2:0] ch,
                                       input logic [9:0] cd);
    logic [19:0] p;
    p = {10'h0, cd} * ((ch == 3'h5) ? 20'h00096 : 20'h000e6);
    if (ch == 3'h4)
      return (cd < 10'h011) ? 10'h011 : (cd > 10'h0e5) ? 10'h0e5 : cd;
    return (ch == 3'h5) ? 10'h12c + p[19:10] : p[19:10];
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, {4'h0, a}, d);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, {4'h0, a}, 32'h0);
    chk(rdat, exp);
  endtask

  task automatic ticks(input int n);
    repeat (n * TK) @(posedge clock);
  endtask

  task automatic single(input logic [2:0] ch, input logic [9:0] cd);
    int s0, n;
    conv.codes[ch] = cd;
    k0 = n_kind[0];
    s0 = seen[ch];
    slow <= seed[3];
    wr(REG_MASK, {31'h0, ch[0]});
    wr(REG_CMD, {23'h0, 1'b1, 5'h0, ch});
    n = 0;
    while (n_kind[0] == k0 && n < 300) begin
      @(posedge clock);
      n++;
    end
    chk(n < 300, 1'b1);
    @(posedge clock);
    chk({17'h0, last}, {17'h0, REP_SINGLE, ch, scale(ch, cd)});
    rdchk(REG_RESULT, {17'h0, ch, 2'h0, scale(ch, cd)});
    if (ch <= 3'h3) chk(seen[ch] - s0, 1);
    rdchk(REG_STATUS, 32'h1);
    chk(irq, ch[0]);
    wr(REG_STATUS, 32'hf);
    rdchk(REG_STATUS, 32'h0);
    chk(irq, 1'b0);
  endtask

  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clock);
    mismatches++;
    give_verdict;
  end

  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    slow = 1'b0;
    seed = 32'he1f79998;
    mismatches = 0;
    n_compared = 0;
    foreach (n_kind[i]) n_kind[i] = 0;
    foreach (seen[i]) seen[i] = 0;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    rdchk(REG_SLEEP, 32'h0);
    rdchk(REG_MASK, 32'h0);
    rdchk(8'h24, 32'h1);
    rdchk(REG_POWER, 32'h0);
    apb(1'b0, 12'h018, 32'h0);
    chk(rerr, 1'b1);
    chk(rdat, 32'h0);
    apb(1'b0, 12'h100, 32'h0);
    chk(rerr, 1'b1);
    $display("test registers done");
    ticks(4);
    chk(seen[5] > 0 && seen[4] > 0, 1'b1);
    chk(n_kind[0] + n_kind[1] + n_kind[2], 0);
    $display("test background done");
    for (int ch = 1; ch <= 5; ch++) begin
      seed = lfsr(seed);
      single(ch[2:0], seed[9:0]);
    end
    single(3'h4, 10'h005);
    single(3'h4, 10'h3ff);
    single(3'h3, 10'h3ff);
    single(3'h4, 10'h07f);
    for (int i = 5; i < 8; i++) begin
      wr(REG_CMD, {23'h0, 1'b1, 5'h0, (i == 5) ? 3'h0 : i[2:0]});
      rdchk(REG_STATUS, 32'h8);
      wr(REG_STATUS, 32'h8);
    end
    $display("test single done");
    // Fast converter keeps one periodic and one scan within a tick
    slow <= 1'b0;
    seed = lfsr(seed);
    c = seed[9:0];
    conv.codes[1] = c;
    wr(8'h24, 32'h2);
    wr(8'h20, {30'h0, MODE_PERIODIC});
    ticks(1);
    k0 = n_kind[1];
    ticks(20);
    chk(n_kind[1] - k0 >= 9 && n_kind[1] - k0 <= 11, 1'b1);
    chk({17'h0, last}, {17'h0, REP_PERIODIC, 3'h1, scale(3'h1, c)});
    wr(REG_SLEEP, 32'h2);
    rdchk(REG_POWER, 32'h1);
    chk(sleep_inhibit, 1'b1);
    wr(REG_SLEEP, 32'h1);
    rdchk(REG_POWER, 32'h0);
    wr(8'h20, 32'h0);
    wr(REG_SLEEP, 32'hffff);
    rdchk(REG_POWER, 32'h0);
    wr(REG_STATUS, 32'hf);
    $display("test periodic done");
    wr(8'h34, 32'h1);
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      c = seed[9:0] | 10'h040;
      v = scale(3'h2, c);
      conv.codes[2] = c;
      wr(8'h38, {6'h0, v - {9'h0, i[2]}, 6'h0, v + {9'h0, i[2]}});
      wr(8'h30, {28'h0, i[1], i[0], MODE_LIMITS});
      ticks(2);
      k0 = n_kind[2] + 100 * n_kind[1];
      ticks(4);
      chk(n_kind[2] + 100 * n_kind[1] - k0, (i[0] | i[1]) & i[2] ? 4 : 0);
      if ((i[0] | i[1]) & i[2])
        chk({17'h0, last}, {17'h0, REP_LIMIT, 3'h2, v});
    end
    wr(8'h30, 32'h0);
    $display("test limits done");
    give_verdict;
  end
endmodule
